// ---- rtl/drc_pkg.sv ----
// Constants, register map and bit positions of the debug run-control block.
// Notes on behaviour
// - Writing one to control bit 7 enters debug halt mode and stops instruction fetch.
// - Writing zero to control bit 7 leaves debug halt mode and lets the core fetch again.
// - A debug breakpoint with the halt select bit at one sets control bit 7 by itself.
// - A debug breakpoint with the halt select bit (bit 6) at zero makes the core loop in place.
// - With the breakpoint enable bit (bit 5) at zero, a break or hardware hit raises a trap.
// - With the breakpoint enable bit at one, such a hit is a debug breakpoint, not a trap.
// - Control bit 4 at one keeps the system clock running in stop mode; at zero it stops.
// - Control bit 0 set in debug halt runs one instruction and clears itself when it retires.
// - Status bit 7 reads one while the core sits in debug halt mode with no single step pending (control bit 0 at zero).
// - Status bit 6 sets on a break instruction and clears when control bit 7 is written zero.
// - Status bits 5 and 4 read one while the device is in halt mode and stop mode.
// - Status bit 3 reads one while memory read protection is enabled.
// - Status bit 1 reads one while the debug transmit holding register holds data.
// - Status bit 0 reads one while the debug receive holding register is empty.
package drc_pkg;

   // ----------------------------------------------------------------------
   // Register map (byte addresses of 32-bit words)
   // ----------------------------------------------------------------------
   localparam logic [7:0] OFF_RUN_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATE    = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;

   // ----------------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------------
   localparam int CTL_HALT      = 7;
   localparam int CTL_HALT_SEL  = 6;
   localparam int CTL_BRK_EN    = 5;
   localparam int CTL_CLK_KEEP  = 4;
   localparam int CTL_STEP      = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ----------------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------------
   localparam int STA_HALT      = 7;
   localparam int STA_BRK_HIT   = 6;
   localparam int STA_LP_HALT   = 5;
   localparam int STA_LP_STOP   = 4;
   localparam int STA_RD_PROT   = 3;
   localparam int STA_TX_FULL   = 1;
   localparam int STA_RX_EMPTY  = 0;
   localparam logic [7:0] STA_RESET = 8'h01;

   // ----------------------------------------------------------------------
   // Interrupt event bits
   // ----------------------------------------------------------------------
   localparam int EVT_W         = 4;
   localparam int EVT_BREAK     = 0;
   localparam int EVT_TRAP      = 1;
   localparam int EVT_STEP      = 2;
   localparam int EVT_HALTED    = 3;
   localparam logic [3:0] EVT_RESET = 4'h0;

endpackage : drc_pkg

// ---- rtl/drc_evt_if.sv ----
// Event and interrupt register signals between the run-control core and its interrupt bank.
`timescale 1ns/100ps
interface drc_evt_if;
   import drc_pkg::*;

   logic [EVT_W-1:0] events;
   logic             statWr;
   logic             maskWr;
   logic [EVT_W-1:0] wrData;
   logic [EVT_W-1:0] irqStat;
   logic [EVT_W-1:0] irqMask;
   logic             irq;

   modport core (output events, output statWr, output maskWr, output wrData,
                 input irqStat, input irqMask, input irq);
   modport bank (input events, input statWr, input maskWr, input wrData,
                 output irqStat, output irqMask, output irq);
endinterface : drc_evt_if

// ---- rtl/drc_irq_bank.sv ----
// Sticky interrupt status with write-one-to-clear, mask and level interrupt.
`timescale 1ns/100ps
module drc_irq_bank
   import drc_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   drc_evt_if.bank   evt
);

   logic [EVT_W-1:0] stat_q;
   logic [EVT_W-1:0] stat_d;
   logic [EVT_W-1:0] mask_q;
   logic             irq_q;

   // New events win over a clear in the same cycle.
   always_comb
   begin
      stat_d = stat_q;
      if (evt.statWr)
      begin
         stat_d = stat_d & ~evt.wrData;
      end
      stat_d = stat_d | evt.events;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         stat_q <= EVT_RESET;
      end
      else
      begin
         stat_q <= stat_d;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         mask_q <= EVT_RESET;
      end
      else if (evt.maskWr)
      begin
         mask_q <= evt.wrData;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(stat_d & (evt.maskWr ? evt.wrData : mask_q));
      end
   end

   assign evt.irqStat = stat_q;
   assign evt.irqMask = mask_q;
   assign evt.irq     = irq_q;

endmodule : drc_irq_bank

// ---- rtl/drc_debug_run_control.sv ----
// Debug run-control block: halt, resume, single step, breakpoint routing and status.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module drc_debug_run_control
   import drc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   // Classic Wishbone slave.
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Core side.
   input  wire logic        breakInstrHit,
   input  wire logic        hwBreakHit,
   input  wire logic        stepRetired,
   input  wire logic        lowPowerHalt,
   input  wire logic        lowPowerStop,
   input  wire logic        readProtectOn,
   input  wire logic        txHoldingFull,
   input  wire logic        rxHoldingEmpty,
   output logic             fetchStop,
   output logic             stepGo,
   output logic             loopOnBreak,
   output logic             illegalTrap,
   output logic             sysClockKeep,
   output logic             irq
);

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   logic       ack_q;
   logic [31:0] rdData_q;
   logic       busReq;
   logic       busWr;
   logic [7:0] wordAdr;
   logic       ctrlWr;
   logic       irqStatWr;
   logic       irqMaskWr;

   assign busReq    = cyc_i && stb_i && !ack_q;
   assign busWr     = busReq && we_i && sel_i[0];
   assign wordAdr   = {adr_i[7:2], 2'b00};
   assign ctrlWr    = busWr && (wordAdr == OFF_RUN_CTRL);
   assign irqStatWr = busWr && (wordAdr == OFF_IRQ_STAT);
   assign irqMaskWr = busWr && (wordAdr == OFF_IRQ_MASK);

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   logic haltBit_q;
   logic haltBit_d;
   logic haltSel_q;
   logic breakpoint_enable_bit_q;
   logic clkKeep_q;
   logic stepBit_q;
   logic stepBit_d;
   logic brkRequest;
   logic brkEvent;
   logic trapEvent;

   assign brkRequest = breakInstrHit || hwBreakHit;
   assign brkEvent   = brkRequest && breakpoint_enable_bit_q;
   assign trapEvent  = brkRequest && !breakpoint_enable_bit_q;

   always_comb
   begin
      haltBit_d = haltBit_q;
      if (ctrlWr)
      begin
         haltBit_d = dat_i[CTL_HALT];
      end
      if (brkEvent && haltSel_q)
      begin
         haltBit_d = 1'b1;
      end
   end

   always_comb
   begin
      stepBit_d = stepBit_q;
      if (stepRetired)
      begin
         stepBit_d = 1'b0;
      end
      if (ctrlWr)
      begin
         stepBit_d = dat_i[CTL_STEP];
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         haltBit_q <= CTL_RESET[CTL_HALT];
         stepBit_q <= CTL_RESET[CTL_STEP];
      end
      else
      begin
         haltBit_q <= haltBit_d;
         stepBit_q <= stepBit_d;
      end
   end

   // Reserved control bits 3:1 are not stored and read back as zero.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         haltSel_q <= CTL_RESET[CTL_HALT_SEL];
         breakpoint_enable_bit_q   <= CTL_RESET[CTL_BRK_EN];
         clkKeep_q <= CTL_RESET[CTL_CLK_KEEP];
      end
      else if (ctrlWr)
      begin
         haltSel_q <= dat_i[CTL_HALT_SEL];
         breakpoint_enable_bit_q   <= dat_i[CTL_BRK_EN];
         clkKeep_q <= dat_i[CTL_CLK_KEEP];
      end
   end

   // ----------------------------------------------------------------------
   // Core run control outputs
   // ----------------------------------------------------------------------
   // A pending step releases fetch for one instruction only while halted.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         fetchStop    <= 1'b0;
         stepGo       <= 1'b0;
         sysClockKeep <= 1'b0;
      end
      else
      begin
         fetchStop    <= haltBit_d && !stepBit_d;
         stepGo       <= haltBit_d && stepBit_d;
         sysClockKeep <= ctrlWr ? dat_i[CTL_CLK_KEEP] : clkKeep_q;
      end
   end

   // The core keeps looping until software touches the control register.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         loopOnBreak <= 1'b0;
      end
      else if (brkEvent && !haltSel_q)
      begin
         loopOnBreak <= 1'b1;
      end
      else if (ctrlWr)
      begin
         loopOnBreak <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         illegalTrap <= 1'b0;
      end
      else
      begin
         illegalTrap <= trapEvent;
      end
   end

   // ----------------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------------
   logic       brkHit_q;
   logic [7:0] state_q;

   // A break arriving with the clearing write still sets the flag.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         brkHit_q <= STA_RESET[STA_BRK_HIT];
      end
      else if (breakInstrHit)
      begin
         brkHit_q <= 1'b1;
      end
      else if (ctrlWr && !dat_i[CTL_HALT])
      begin
         brkHit_q <= 1'b0;
      end
   end

   // Writes to the status word are acknowledged and ignored.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state_q <= STA_RESET;
      end
      else
      begin
         state_q[STA_HALT]     <= haltBit_q && fetchStop;
         state_q[STA_BRK_HIT]  <= brkHit_q;
         state_q[STA_LP_HALT]  <= lowPowerHalt;
         state_q[STA_LP_STOP]  <= lowPowerStop;
         state_q[STA_RD_PROT]  <= readProtectOn;
         state_q[2]            <= 1'b0;
         state_q[STA_TX_FULL]  <= txHoldingFull;
         state_q[STA_RX_EMPTY] <= rxHoldingEmpty;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt bank
   // ----------------------------------------------------------------------
   drc_evt_if evtBus ();

   assign evtBus.events[EVT_BREAK]  = brkEvent;
   assign evtBus.events[EVT_TRAP]   = trapEvent;
   assign evtBus.events[EVT_STEP]   = stepRetired && stepBit_q;
   assign evtBus.events[EVT_HALTED] = haltBit_d && !haltBit_q;
   assign evtBus.statWr             = irqStatWr;
   assign evtBus.maskWr             = irqMaskWr;
   assign evtBus.wrData             = dat_i[EVT_W-1:0];

   drc_irq_bank u_irqBank (
      .clock (clock),
      .rst   (rst),
      .evt   (evtBus)
   );

   assign irq = evtBus.irq;

   // ----------------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ack_q    <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q    <= busReq;
         rdData_q <= 32'h0000_0000;
         if (busReq && !we_i)
         begin
            case (wordAdr)
               OFF_RUN_CTRL: rdData_q[7:0] <= {haltBit_q, haltSel_q, breakpoint_enable_bit_q, clkKeep_q,
                                               3'h0, stepBit_q};
               OFF_STATE:    rdData_q[7:0] <= state_q;
               OFF_IRQ_STAT: rdData_q[EVT_W-1:0] <= evtBus.irqStat;
               OFF_IRQ_MASK: rdData_q[EVT_W-1:0] <= evtBus.irqMask;
               default:      rdData_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign ack_o = ack_q;
   assign dat_o = rdData_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_haltEnter;
      @(posedge clock) disable iff (rst)
      (ctrlWr && dat_i[CTL_HALT] && !dat_i[CTL_STEP]) |=> fetchStop;
   endproperty
   a_haltEnter: assert property (p_haltEnter) else $error("halt write did not stop fetch");

   property p_haltLeave;
      @(posedge clock) disable iff (rst)
      (ctrlWr && !dat_i[CTL_HALT] && !brkEvent) |=> !fetchStop ##1 !state_q[STA_HALT];
   endproperty
   a_haltLeave: assert property (p_haltLeave) else $error("resume did not restart fetch");

   property p_brkHalts;
      @(posedge clock) disable iff (rst)
      (brkRequest && breakpoint_enable_bit_q && haltSel_q) |=> haltBit_q ##1 state_q[STA_HALT] || stepBit_q;
   endproperty
   a_brkHalts: assert property (p_brkHalts) else $error("breakpoint did not halt");

   property p_brkLoops;
      @(posedge clock) disable iff (rst)
      (brkRequest && breakpoint_enable_bit_q && !haltSel_q) |=> loopOnBreak && !illegalTrap;
   endproperty
   a_brkLoops: assert property (p_brkLoops) else $error("breakpoint did not loop");

   property p_trapWhenOff;
      @(posedge clock) disable iff (rst)
      (brkRequest && !breakpoint_enable_bit_q) |=> illegalTrap && !evtBus.events[EVT_BREAK];
   endproperty
   a_trapWhenOff: assert property (p_trapWhenOff) else $error("missing trap");

   property p_noTrapWhenOn;
      @(posedge clock) disable iff (rst)
      (brkRequest && breakpoint_enable_bit_q) |=> !illegalTrap;
   endproperty
   a_noTrapWhenOn: assert property (p_noTrapWhenOn) else $error("trap with breaks on");

   property p_clockKeep;
      @(posedge clock) disable iff (rst)
      ctrlWr |=> (sysClockKeep == $past(dat_i[CTL_CLK_KEEP]));
   endproperty
   a_clockKeep: assert property (p_clockKeep) else $error("clock keep mismatch");

   property p_stepOnce;
      @(posedge clock) disable iff (rst)
      (stepRetired && !ctrlWr) |=> !stepBit_q ##1 !stepGo;
   endproperty
   a_stepOnce: assert property (p_stepOnce) else $error("step bit not cleared");

   property p_brkFlagClear;
      @(posedge clock) disable iff (rst)
      (ctrlWr && !dat_i[CTL_HALT] && !breakInstrHit) |=> !brkHit_q ##1 !state_q[STA_BRK_HIT];
   endproperty
   a_brkFlagClear: assert property (p_brkFlagClear) else $error("break flag kept");

   property p_rxEmptyMirror;
      @(posedge clock) disable iff (rst)
      ##1 (state_q[STA_RX_EMPTY] == $past(rxHoldingEmpty)) && !state_q[2];
   endproperty
   a_rxEmptyMirror: assert property (p_rxEmptyMirror) else $error("status mirror wrong");

endmodule : drc_debug_run_control

// ---- tb/drc_core_model.sv ----
// Behavioural model of the processor core under debug run control.
`timescale 1ns/100ps
module drc_core_model
   import drc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       brkReq,
   input  wire logic       hwReq,
   input  wire logic [3:0] stepDelay,
   input  wire logic       fetchStop,
   input  wire logic       stepGo,
   output logic            breakInstrHit,
   output logic            hwBreakHit,
   output logic            stepRetired
);
   logic [3:0] cntQ;
   logic       busyQ;

   // A halted core executes nothing, so it cannot hit a breakpoint.
   assign breakInstrHit = brkReq & ~fetchStop;
   assign hwBreakHit    = hwReq & ~fetchStop;

   // The granted instruction retires stepDelay+1 cycles later, once per grant.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cntQ        <= 4'h0;
         busyQ       <= 1'b0;
         stepRetired <= 1'b0;
      end
      else
      begin
         stepRetired <= 1'b0;
         if (stepGo && !busyQ && !stepRetired)
         begin
            busyQ <= 1'b1;
            cntQ  <= stepDelay;
         end
         else if (busyQ && cntQ == 4'h0)
         begin
            busyQ       <= 1'b0;
            stepRetired <= 1'b1;
         end
         else if (busyQ)
            cntQ <= cntQ - 4'h1;
      end
   end
endmodule : drc_core_model

// ---- tb/drc_debug_run_control_test.sv ----
// Register-level testbench of the debug run-control block.
`timescale 1ns/100ps
module drc_debug_run_control_test;
   import drc_pkg::*;
   logic        clock, rst, cyc, stb, we, ack, brkReq, hwReq, bih, hwh, stepRet;
   logic        lpHalt, lpStop, rdProt, txFull, rxEmpty, fetchStop, stepGo;
   logic        loopOnBreak, illegalTrap, sysClockKeep, irq;
   logic [3:0]  sel, stepDelay;
   logic [7:0]  adr;
   logic [31:0] wdat, rdat, q;
   int          mismatches, nCompared, trapCount, stepCount;

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   drc_debug_run_control dut_u (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .breakInstrHit(bih), .hwBreakHit(hwh), .stepRetired(stepRet),
      .lowPowerHalt(lpHalt), .lowPowerStop(lpStop), .readProtectOn(rdProt),
      .txHoldingFull(txFull), .rxHoldingEmpty(rxEmpty), .fetchStop(fetchStop),
      .stepGo(stepGo), .loopOnBreak(loopOnBreak), .illegalTrap(illegalTrap),
      .sysClockKeep(sysClockKeep), .irq(irq));

   drc_core_model core_u (.clock(clock), .rst(rst), .brkReq(brkReq), .hwReq(hwReq),
      .stepDelay(stepDelay), .fetchStop(fetchStop), .stepGo(stepGo),
      .breakInstrHit(bih), .hwBreakHit(hwh), .stepRetired(stepRet));

   always @(posedge clock)
   begin
      if (illegalTrap === 1'b1)
         trapCount++;
      if (stepRet === 1'b1)
         stepCount++;
   end

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic end_of_test;
      if (mismatches == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                       input logic [7:0] d);
      int n;
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= {24'h0, d};
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (ack !== 1'b1 && n < 16);
      if (ack !== 1'b1)
      begin
         mismatches++;
         end_of_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clock);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, 4'h1, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
      xfer(1'b0, a, 4'h1, 8'h0);
      chk(name, {24'h0, e}, q);
   endtask : rd

   task automatic hit(input logic hw);
      hwReq  <= hw;
      brkReq <= ~hw;
      @(posedge clock);
      hwReq  <= 1'b0;
      brkReq <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : hit

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      {cyc, stb, we, lpHalt, lpStop, rdProt, txFull, brkReq, hwReq} = '0;
      rst = 1'b1;
      rxEmpty = 1'b1;
      adr = 8'h0;
      sel = 4'h0;
      wdat = 32'h0;
      stepDelay = 4'h0;
      {mismatches, nCompared, trapCount, stepCount} = '0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      rd(OFF_RUN_CTRL, 8'h00, "ctrl reset");
      rd(OFF_STATE, 8'h01, "status reset");
      rd(8'h10, 8'h00, "unmapped");
      {lpHalt, lpStop, rdProt, txFull, rxEmpty} <= 5'b11110;
      repeat (2) @(posedge clock);
      rd(OFF_STATE, 8'h3A, "status mirrors");
      wr(OFF_STATE, 8'hFB);
      rd(OFF_STATE, 8'h3A, "status written");
      {lpHalt, lpStop, rdProt, txFull, rxEmpty} <= 5'b00001;
      xfer(1'b1, OFF_RUN_CTRL, 4'h0, 8'h10);
      chk("keep unselected", 32'h0, 32'(sysClockKeep));
      wr(OFF_RUN_CTRL, 8'h10);
      chk("keep on", 32'h1, 32'(sysClockKeep));
      wr(OFF_RUN_CTRL, 8'h00);
      chk("keep off", 32'h0, 32'(sysClockKeep));
      wr(OFF_RUN_CTRL, 8'h80);
      chk("halt fetch", 32'h1, 32'(fetchStop));
      rd(OFF_STATE, 8'h81, "halt status");
      // A prompt and a slow core each retire exactly one stepped instruction.
      for (int i = 0; i < 2; i++)
      begin
         stepDelay <= 4'(i * 5);
         wr(OFF_RUN_CTRL, 8'h81);
         chk("step go", 32'h1, 32'(stepGo));
         for (int n = 0; n < 32 && stepGo !== 1'b0; n++)
            @(posedge clock);
         if (stepGo !== 1'b0)
         begin
            mismatches++;
            end_of_test();
         end
         rd(OFF_RUN_CTRL, 8'h80, "step cleared");
         chk("step count", 32'(i + 1), 32'(stepCount));
         chk("halt after step", 32'h1, 32'(fetchStop));
      end
      wr(OFF_RUN_CTRL, 8'h00);
      chk("resume", 32'h0, 32'(fetchStop));
      rd(OFF_STATE, 8'h01, "run status");
      rd(OFF_IRQ_STAT, 8'h0C, "irq halt and step");
      wr(OFF_IRQ_STAT, 8'h0F);
      wr(OFF_IRQ_MASK, 8'h00);
      hit(1'b0);
      chk("trap break", 32'h1, 32'(trapCount));
      hit(1'b1);
      chk("trap hw", 32'h2, 32'(trapCount));
      chk("trap no halt", 32'h0, 32'(fetchStop));
      rd(OFF_STATE, 8'h41, "break flag");
      rd(OFF_IRQ_STAT, 8'h02, "irq trap");
      chk("irq masked", 32'h0, 32'(irq));
      wr(OFF_IRQ_MASK, 8'h02);
      repeat (2) @(posedge clock);
      chk("irq on", 32'h1, 32'(irq));
      wr(OFF_IRQ_STAT, 8'h02);
      repeat (2) @(posedge clock);
      chk("irq cleared", 32'h0, 32'(irq));
      rd(OFF_IRQ_STAT, 8'h00, "irq status cleared");
      wr(OFF_RUN_CTRL, 8'h60);
      hit(1'b0);
      chk("break halts", 32'h1, 32'(fetchStop));
      chk("break no trap", 32'h2, 32'(trapCount));
      rd(OFF_RUN_CTRL, 8'hE0, "auto halt");
      rd(OFF_IRQ_STAT, 8'h09, "irq break halt");
      rd(OFF_STATE, 8'hC1, "break status");
      wr(OFF_RUN_CTRL, 8'h60);
      rd(OFF_STATE, 8'h01, "break flag clear");
      wr(OFF_RUN_CTRL, 8'h20);
      hit(1'b1);
      chk("loop set", 32'h1, 32'(loopOnBreak));
      chk("loop no halt", 32'h0, 32'(fetchStop));
      chk("loop no trap", 32'h2, 32'(trapCount));
      wr(OFF_RUN_CTRL, 8'h20);
      chk("loop released", 32'h0, 32'(loopOnBreak));
      end_of_test();
   end
endmodule : drc_debug_run_control_test
